// ===== aesl_top.sv
// accessory status, event latch and interrupt enable logic of the transceiver
// Overview of operation
// RQ1 - the status register at 20h is read-only and writes to it do nothing.
// RQ2 - status bit 0 shows the id float state, meaningful only with the pull-up on.
// RQ3 - status bit 1 shows the live line voltage comparator, valid with the sink on.
// RQ4 - bit 2 of status and latch registers always reads zero.
// RQ5 - status bits 5:3 show the id resistor conversion code.
// RQ6 - status bit 6 sets when a conversion finishes after 282 us.
// RQ7 - the done flag clears when the code is read through the vendor register.
// RQ8 - reading status at 20h does not clear the done flag.
// RQ9 - the latch register at 21h clears its implemented bits when read.
// RQ10 - latch bit 0 sets on enabled float rise or float fall of the id pin.
// RQ11 - latch bit 1 sets on any comparator change while its enable is on.
// RQ12 - latch bit 3 sets on a done flag rise while enabled; bits 7:4 read zero.
// RQ13 - the link reaches vendor registers 30h to 3Fh by immediate accesses.
// RQ14 - a latched enabled event raises alt_int toward the link.
// RQ15 - the enable register is written at 1Dh, set at 1Eh, cleared at 1Fh.
// RQ16 - the conversion enable is the or of this enable and the vendor one.
// RQ17 - an event in the cycle of a latch read stays latched.
`timescale 1ns/1ps
`default_nettype none
module aesl_top #(
	parameter int CONV_CYCLES_P = aesl_pkg::CONV_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire aesl_pkg::aesl_req_t REQ_I,
	input wire aesl_pkg::aesl_sense_t SENSE_I,
	input wire logic ID_PULLUP_ENABLE_I,
	input wire logic CURRENT_SINK_ENABLE_I,
	input wire logic VENDOR_CONV_IRQ_ENABLE_I,
	input wire logic CONV_START_I,
	output logic [7:0] RDATA_O,
	output logic CONV_BUSY_O,
	output logic ALT_INT_O
);
	import aesl_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic [7:0] irq_en_reg, irq_en_next;
	logic [3:0] event_reg, event_next;
	logic done_reg, done_next;
	logic float_reg, float_next;
	logic volt_reg, volt_next;
	logic [2:0] code_reg, code_next;
	logic [7:0] rdata_reg, rdata_next;
	logic conv_done_pulse;
	logic float_now, volt_now;
	logic conv_en, done_rise;
	logic [7:0] status_val, latch_val;
	logic [7:0] wmask;

	aesl_conv_timer #(
		.CYCLES(CONV_CYCLES_P)
	) u_timer (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.start_i(CONV_START_I),
		.busy_o(CONV_BUSY_O),
		.done_o(conv_done_pulse)
	);

	// gate the analog indications with their enables so stale levels never show
	assign float_now = SENSE_I.id_float & ID_PULLUP_ENABLE_I; // see RQ2
	assign volt_now = SENSE_I.line_voltage & CURRENT_SINK_ENABLE_I; // see RQ3
	assign conv_en = irq_en_reg[EN_CONV] | VENDOR_CONV_IRQ_ENABLE_I; // see RQ16

	always_comb begin
		status_val = '0;
		status_val[BIT_ID_FLOAT] = float_reg;
		status_val[BIT_LINE_VOLT] = volt_reg;
		status_val[BIT_DPLUS] = 1'b0; // see RQ4
		status_val[BIT_RID_HI:BIT_RID_LO] = code_reg; // see RQ5
		status_val[BIT_CONV_DONE] = done_reg;
		latch_val = {4'h0, event_reg}; // see RQ12
		latch_val[BIT_DPLUS] = 1'b0; // see RQ4
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		irq_en_next = irq_en_reg;
		float_next = float_now;
		volt_next = volt_now;
		code_next = SENSE_I.id_resistor_code; // see RQ5
		done_next = done_reg;
		event_next = event_reg;
		rdata_next = rdata_reg;
		wmask = REQ_I.wdata & IRQ_EN_MASK;

		// writes to 20h/21h fall through untouched
		if (REQ_I.wr) begin // see RQ1
			unique case (REQ_I.addr)
				ADDR_IRQ_EN_WRITE: irq_en_next = wmask; // see RQ15
				ADDR_IRQ_EN_SET: irq_en_next = irq_en_reg | wmask;
				ADDR_IRQ_EN_CLEAR: irq_en_next = irq_en_reg & ~wmask;
				default: irq_en_next = irq_en_reg;
			endcase
		end

		if (REQ_I.rd) begin
			unique case (REQ_I.addr)
				ADDR_IRQ_EN_WRITE, ADDR_IRQ_EN_SET, ADDR_IRQ_EN_CLEAR:
					rdata_next = irq_en_reg;
				ADDR_STATUS: rdata_next = status_val; // see RQ8
				ADDR_EVENT_LATCH: begin
					rdata_next = latch_val;
					event_next = EVENT_RESET; // see RQ9
				end
				default: rdata_next = 8'h00;
			endcase
		end

		// clear by vendor read, but a completion in the same cycle wins
		if (REQ_I.rd && REQ_I.addr == ADDR_RID_CONV_READ) begin
			done_next = 1'b0; // see RQ7
		end
		if (conv_done_pulse) begin
			done_next = 1'b1; // see RQ6
		end
		// rise taken from the final next value, so bit 3 sets with bit 6
		done_rise = done_next & ~done_reg;

		// event sets come last so they override a same-cycle read clear
		if ((float_now & ~float_reg & irq_en_reg[EN_FLOAT_RISE]) |
				(~float_now & float_reg & irq_en_reg[EN_FLOAT_FALL])) begin
			event_next[BIT_ID_FLOAT] = 1'b1; // see RQ10, RQ17
		end
		if ((volt_now ^ volt_reg) & irq_en_reg[EN_LINE_VOLT]) begin
			event_next[BIT_LINE_VOLT] = 1'b1; // see RQ11, RQ17
		end
		if (done_rise & conv_en) begin
			event_next[BIT_CONV_EVENT] = 1'b1; // see RQ12, RQ17
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			irq_en_reg <= IRQ_EN_RESET;
			event_reg <= EVENT_RESET;
			done_reg <= 1'b0;
			float_reg <= 1'b0;
			volt_reg <= 1'b0;
			code_reg <= 3'h0;
			rdata_reg <= 8'h00;
		end else begin
			irq_en_reg <= irq_en_next;
			event_reg <= event_next;
			done_reg <= done_next;
			float_reg <= float_next;
			volt_reg <= volt_next;
			code_reg <= code_next;
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA_O = rdata_reg;
	// the rxcmd builder outside folds this into its alt_int bit
	assign ALT_INT_O = |event_reg; // see RQ14
endmodule
`default_nettype wire

// ===== aesl_pkg.sv
// package of register map, field layout and timing constants for the accessory event latch
package aesl_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [5:0] ADDR_IRQ_EN_WRITE = 6'h1d;
	localparam logic [5:0] ADDR_IRQ_EN_SET = 6'h1e;
	localparam logic [5:0] ADDR_IRQ_EN_CLEAR = 6'h1f;
	localparam logic [5:0] ADDR_STATUS = 6'h20;
	localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
	localparam logic [5:0] ADDR_RID_CONV_READ = 6'h36;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_ID_FLOAT = 0;
	localparam int BIT_LINE_VOLT = 1;
	localparam int BIT_DPLUS = 2;
	localparam int BIT_RID_LO = 3;
	localparam int BIT_RID_HI = 5;
	localparam int BIT_CONV_DONE = 6;
	localparam int BIT_CONV_EVENT = 3;
	localparam int EN_FLOAT_RISE = 0;
	localparam int EN_FLOAT_FALL = 1;
	localparam int EN_LINE_VOLT = 2;
	localparam int EN_CONV = 5;

	// implemented bits of the enable register
	localparam logic [7:0] IRQ_EN_MASK = 8'h27;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [3:0] EVENT_RESET = 4'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CONV_TIME_NS = 282000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic id_float;
		logic line_voltage;
		logic [2:0] id_resistor_code;
	} aesl_sense_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} aesl_req_t;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_BUSY = 2'b01
	} aesl_conv_state_t;

endpackage

// ===== aesl_conv_timer.sv
// conversion timer: counts the conversion time and pulses on completion
`timescale 1ns/1ps
`default_nettype none
module aesl_conv_timer #(
	parameter int CYCLES = aesl_pkg::CONV_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o
);
	import aesl_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);

	aesl_conv_state_t state_reg, state_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic done_reg, done_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		unique case (state_reg)
			CONV_IDLE: begin
				if (start_i) begin
					state_next = CONV_BUSY;
					cnt_next = CW'(CYCLES - 1);
				end
			end
			CONV_BUSY: begin
				if (cnt_reg == '0) begin
					state_next = CONV_IDLE;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default: state_next = CONV_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= CONV_IDLE;
			cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy_o = (state_reg == CONV_BUSY);
	assign done_o = done_reg;
endmodule
`default_nettype wire

// ===== aesl_asserts.sv
// port checker of the accessory event latch
`timescale 1ns/1ps
`default_nettype none
module aesl_asserts
	import aesl_pkg::*;
#(
	parameter int CONV_CYCLES_P = 10
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire aesl_pkg::aesl_req_t REQ_I,
	input wire aesl_pkg::aesl_sense_t SENSE_I,
	input wire logic ID_PULLUP_ENABLE_I,
	input wire logic CURRENT_SINK_ENABLE_I,
	input wire logic VENDOR_CONV_IRQ_ENABLE_I,
	input wire logic CONV_START_I,
	input wire logic [7:0] RDATA_O,
	input wire logic CONV_BUSY_O,
	input wire logic ALT_INT_O
);
	wire logic rd20 = REQ_I.rd && REQ_I.addr == ADDR_STATUS;
	wire logic rd21 = REQ_I.rd && REQ_I.addr == ADDR_EVENT_LATCH;
	wire logic rd36 = REQ_I.rd && REQ_I.addr == ADDR_RID_CONV_READ;
	// helper model of the done flag and of the busy length, seen from ports
	logic busy_q;
	logic done_flag;
	int busy_cnt;
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			busy_q <= 1'b0;
			done_flag <= 1'b0;
			busy_cnt <= 0;
		end else begin
			busy_q <= CONV_BUSY_O;
			if (busy_q && !CONV_BUSY_O)
				done_flag <= 1'b1;
			else if (rd36)
				done_flag <= 1'b0;
			if (CONV_BUSY_O)
				busy_cnt <= busy_cnt + 1;
			else
				busy_cnt <= 0;
		end
	end
	// every level that can raise an event, so a quiet read can be told apart
	wire logic [6:0] lv = {SENSE_I, ID_PULLUP_ENABLE_I, CURRENT_SINK_ENABLE_I};
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	status_gaps_a: assert property (rd20 |=> !RDATA_O[7] && !RDATA_O[2])
		else $error("status gap bits set");
	latch_gaps_a: assert property (rd21 |=> RDATA_O[7:4] == 4'h0 && !RDATA_O[2])
		else $error("latch gap bits set");
	float_gate_a: assert property (rd20 && !ID_PULLUP_ENABLE_I &&
		!$past(ID_PULLUP_ENABLE_I) |=> !RDATA_O[0]) else $error("float not gated");
	line_gate_a: assert property (rd20 && !CURRENT_SINK_ENABLE_I &&
		!$past(CURRENT_SINK_ENABLE_I) |=> !RDATA_O[1]) else $error("line not gated");
	idle_latch_a: assert property (rd21 && !ALT_INT_O |=> RDATA_O[3:0] == 4'h0)
		else $error("latch set without alt_int");
	quiet_clear_a: assert property (rd21 && lv == $past(lv) &&
		lv == $past(lv, 2) && !CONV_BUSY_O && !$past(CONV_BUSY_O) &&
		!$past(CONV_BUSY_O, 2) |=> !ALT_INT_O) else $error("read did not clear");
	start_busy_a: assert property (CONV_START_I && !CONV_BUSY_O |=> CONV_BUSY_O)
		else $error("start ignored");
	busy_len_a: assert property ($fell(CONV_BUSY_O) |-> busy_cnt == CONV_CYCLES_P)
		else $error("conversion length wrong");
	done_irq_a: assert property ($fell(CONV_BUSY_O) && VENDOR_CONV_IRQ_ENABLE_I &&
		!done_flag && !rd21 ##1 !rd21 ##1 !rd21 |-> ALT_INT_O)
		else $error("no done interrupt");
	cover property (rd21 ##1 RDATA_O[0]);
	cover property (rd21 ##1 RDATA_O[3]);
	cover property ($fell(CONV_BUSY_O));
endmodule
bind aesl_top aesl_asserts #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk_i (.CLK_I(CLK_I),
	.RST_I(RST_I), .REQ_I(REQ_I), .SENSE_I(SENSE_I), .CONV_START_I(CONV_START_I),
	.ID_PULLUP_ENABLE_I(ID_PULLUP_ENABLE_I), .RDATA_O(RDATA_O),
	.CURRENT_SINK_ENABLE_I(CURRENT_SINK_ENABLE_I), .CONV_BUSY_O(CONV_BUSY_O),
	.VENDOR_CONV_IRQ_ENABLE_I(VENDOR_CONV_IRQ_ENABLE_I), .ALT_INT_O(ALT_INT_O));
`default_nettype wire

// ===== aesl_link.sv
// link controller model issuing immediate register accesses
`timescale 1ns/1ps
`default_nettype none
module aesl_link (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output var aesl_pkg::aesl_req_t req_o
);
	initial req_o = '0;
	// one-cycle strobe, then an idle cycle so strobes never merge
	task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		req_o = {~wr, wr, a, d};
		@(negedge clk_i);
		req_o = '0;
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

// ===== aesl_top_bench.sv
// self-checking bench of the accessory event latch
`timescale 1ns/1ps
`default_nettype none
module aesl_top_bench;
	import aesl_pkg::*;
	logic clk = 0, rst = 1, pu = 0, sk = 0, ven = 0, st = 0, by, ai;
	aesl_sense_t sn = '0;
	aesl_req_t rq;
	logic [7:0] rd, q;
	localparam int SIM_CONV = 10;
	int error_cnt = 0, check_count = 0, cyc = 0, busy_n = 0;
	aesl_top #(.CONV_CYCLES_P(SIM_CONV)) DUT (.CLK_I(clk), .RST_I(rst), .REQ_I(rq),
		.SENSE_I(sn), .ID_PULLUP_ENABLE_I(pu), .CURRENT_SINK_ENABLE_I(sk),
		.VENDOR_CONV_IRQ_ENABLE_I(ven), .CONV_START_I(st), .RDATA_O(rd),
		.CONV_BUSY_O(by), .ALT_INT_O(ai));
	aesl_link LNK (.clk_i(clk), .rdata_i(rd), .req_o(rq));
	initial forever #4 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
		LNK.acc(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), q, exp);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		LNK.acc(1'b1, a, d, q);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		sn = 5'b11101;
		repeat (2) @(negedge clk);
		rdc(ADDR_STATUS, 8'h28);
		pu = 1;
		sk = 1;
		repeat (2) @(negedge clk);
		wr(ADDR_STATUS, 8'hff);
		rdc(ADDR_STATUS, 8'h2b);
		rdc(ADDR_EVENT_LATCH, 8'h00);
		for (int i = 0; i < 8; i++) begin
			sn.id_resistor_code = i[2:0];
			repeat (2) @(negedge clk);
			rdc(ADDR_STATUS, {2'b00, i[2:0], 3'b011});
		end
		wr(ADDR_IRQ_EN_WRITE, 8'hff);
		rdc(ADDR_IRQ_EN_WRITE, 8'h27);
		wr(ADDR_IRQ_EN_CLEAR, 8'h01);
		rdc(ADDR_IRQ_EN_SET, 8'h26);
		wr(ADDR_IRQ_EN_SET, 8'h01);
		wr(ADDR_IRQ_EN_CLEAR, 8'h01);
		sn.id_float = 0;
		repeat (2) @(negedge clk);
		rdc(ADDR_EVENT_LATCH, 8'h01);
		rdc(ADDR_EVENT_LATCH, 8'h00);
		sn.id_float = 1;
		repeat (2) @(negedge clk);
		rdc(ADDR_EVENT_LATCH, 8'h00);
		sn.line_voltage = 0;
		repeat (2) @(negedge clk);
		chk("alt_int", {7'h00, ai}, 8'h01);
		rdc(ADDR_EVENT_LATCH, 8'h02);
		// comparator change lands on the very edge of the clearing read
		fork
			rdc(ADDR_EVENT_LATCH, 8'h00);
			begin
				@(negedge clk);
				sn.line_voltage = 1;
			end
		join
		rdc(ADDR_EVENT_LATCH, 8'h02);
		wr(ADDR_IRQ_EN_WRITE, 8'h00);
		sn.line_voltage = 0;
		ven = 1;
		st = 1;
		@(negedge clk);
		st = 0;
		repeat (40) begin
			if (by !== 1'b1)
				break;
			busy_n++;
			@(negedge clk);
		end
		chk("busy_len", 8'(busy_n), 8'(SIM_CONV));
		repeat (2) @(negedge clk);
		chk("alt_int", {7'h00, ai}, 8'h01);
		rdc(ADDR_STATUS, 8'h79);
		rdc(ADDR_STATUS, 8'h79);
		rdc(ADDR_EVENT_LATCH, 8'h08);
		LNK.acc(1'b0, ADDR_RID_CONV_READ, 8'h00, q);
		rdc(ADDR_STATUS, 8'h39);
		stop_test();
	end
endmodule
`default_nettype wire
